/* src/rxg_top.sv */
// rxg_top: receive guard and check configuration block with apb register access
`timescale 1ns/100ps
`default_nettype none
module rxg_top
	import rxg_pkg::*;
(
	input wire logic clk_i, // clock, 25 MHz
	input wire logic rstn_i, // async reset, low
	input wire logic [7:0] paddr_i, // apb byte address
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb access phase
	input wire logic pwrite_i, // apb write
	input wire logic [31:0] pwdata_i, // apb write data
	input wire logic [3:0] pstrb_i, // apb byte strobes
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	input wire logic guard_trig_i, // event that starts the guard time
	input wire logic rx_start_i, // receiver sees a frame start
	input wire logic rx_end_i, // frame end
	input wire logic rx_bit_valid_i, // decoded bit strobe
	input wire logic rx_bit_i, // decoded bit value
	input wire logic rx_coll_i, // collision on this bit
	input wire logic crc_err_i, // crc mismatch pulse from crc unit
	input wire logic md_valid_i, // mode detector result strobe
	input wire logic [1:0] md_proto_i, // recognised protocol
	output logic rx_allow_o, // guard time over, frame may start
	output logic rx_byte_valid_o, // byte strobe
	output logic [7:0] rx_byte_o, // received byte
	output logic rx_par_err_o, // parity error pulse
	output logic integ_err_o, // sticky integrity error flag
	output logic [15:0] crc_seed_o, // crc preset for the decoder
	output logic crc_type5_o, // 5-bit crc selected
	output logic crc_inv_o, // inverted crc compare
	output logic crc_en_o // crc check enabled
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0] grd_q, grd_d, chk_q, chk_d, prdata_q, prdata_d;
	logic err_q, err_d;
	logic [15:0] seed_q, seed_d;
	logic busy, acc_start, par_err, active, byte_valid;
	logic [7:0] rx_byte;
	logic sel_grd, sel_chk, sel_st, hit, wr_en;
	logic [31:0] rd_mux, stat_w;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign sel_grd = (paddr_i[7:2] == RXG_GUARD_IDX);
	assign sel_chk = (paddr_i[7:2] == RXG_CHECK_IDX);
	assign sel_st = (paddr_i[7:2] == RXG_STAT_IDX);
	assign hit = sel_grd | sel_chk | sel_st;
	assign wr_en = psel_i & penable_i & pwrite_i & hit;

	always_comb begin
		stat_w = '0;
		stat_w[RXG_ST_BUSY_BIT] = busy;
		stat_w[RXG_ST_ERR_BIT] = err_q;
		stat_w[RXG_ST_ACT_BIT] = active;
		stat_w[RXG_ST_BYTE_LSB +: 8] = rx_byte;
		rd_mux = '0;
		if (sel_grd) begin
			rd_mux = grd_q;
		end else if (sel_chk) begin
			rd_mux = chk_q;
		end else if (sel_st) begin
			rd_mux = stat_w;
		end
	end

	// read data is captured in the setup cycle so the access phase needs no wait
	always_comb begin
		prdata_d = prdata_q;
		if (psel_i && !penable_i && !pwrite_i) begin
			prdata_d = rd_mux;
		end
	end

	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit;
	assign prdata_o = prdata_q;

	// ----------------------------------------------------------------
	// configuration registers and mode detector updates
	// ----------------------------------------------------------------
	always_comb begin
		grd_d = grd_q;
		chk_d = chk_q;
		if (wr_en && sel_grd) begin
			grd_d = rxg_merge(grd_q, pwdata_i, pstrb_i, RXG_GUARD_MASK);
		end
		if (wr_en && sel_chk) begin
			chk_d = rxg_merge(chk_q, pwdata_i, pstrb_i, RXG_CHECK_MASK);
		end
		// detector result lands after the bus write, so it wins a same-cycle clash
		if (md_valid_i) begin
			unique case (rxg_proto_t'(md_proto_i))
				RXG_PROTO_A: begin
					chk_d[RXG_PAR_EN_BIT] = 1'b1;
					chk_d[RXG_PAR_ODD_BIT] = 1'b1;
					chk_d[RXG_SEL_LSB +: 3] = RXG_SEL_A;
					chk_d[RXG_INV_BIT] = 1'b0;
				end
				RXG_PROTO_B: begin
					chk_d[RXG_SEL_LSB +: 3] = RXG_SEL_B;
					chk_d[RXG_INV_BIT] = 1'b1;
					chk_d[RXG_CRCEN_BIT] = 1'b1;
				end
				RXG_PROTO_JIS: begin
					chk_d[RXG_SEL_LSB +: 3] = RXG_SEL_ZERO;
					chk_d[RXG_INV_BIT] = 1'b0;
					chk_d[RXG_CRCEN_BIT] = 1'b1;
				end
				default: begin
					chk_d = chk_d;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// integrity flag and crc seed
	// ----------------------------------------------------------------
	assign acc_start = rx_start_i & ~busy;

	always_comb begin
		err_d = err_q;
		if (acc_start) begin
			err_d = 1'b0;
		end
		// an error in the same cycle as a new start is kept, set beats clear
		if (par_err || crc_err_i) begin
			err_d = 1'b1;
		end
		seed_d = rxg_seed(chk_q[RXG_SEL_LSB +: 3], chk_q[RXG_PRESET_LSB +: 16],
			chk_q[RXG_TYPE5_BIT]);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			grd_q <= RXG_GUARD_RST;
			chk_q <= RXG_CHECK_RST;
			prdata_q <= '0;
			err_q <= 1'b0;
			seed_q <= RXG_SEED_ZERO;
		end else begin
			grd_q <= grd_d;
			chk_q <= chk_d;
			prdata_q <= prdata_d;
			err_q <= err_d;
			seed_q <= seed_d;
		end
	end

	// ----------------------------------------------------------------
	// guard timer and bit assembly
	// ----------------------------------------------------------------
	rxg_guard #(
		.PRESC_W(RXG_PRESC_W),
		.RELOAD_W(RXG_RELOAD_W)
	) u_guard (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.trig_i(guard_trig_i),
		.presc_i(grd_q[RXG_PRESC_LSB +: RXG_PRESC_W]),
		.reload_i(grd_q[RXG_RELOAD_LSB +: RXG_RELOAD_W]),
		.busy_o(busy)
	);

	rxg_pack u_pack (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.start_i(acc_start),
		.end_i(rx_end_i),
		.bit_valid_i(rx_bit_valid_i),
		.bit_i(rx_bit_i),
		.coll_i(rx_coll_i),
		.par_en_i(chk_q[RXG_PAR_EN_BIT]),
		.par_odd_i(chk_q[RXG_PAR_ODD_BIT]),
		.keep_i(chk_q[RXG_KEEP_BIT]),
		.align_i(chk_q[RXG_ALIGN_LSB +: 3]),
		.byte_valid_o(byte_valid),
		.byte_o(rx_byte),
		.par_err_o(par_err),
		.active_o(active)
	);

	assign rx_allow_o = ~busy;
	assign rx_byte_valid_o = byte_valid;
	assign rx_byte_o = rx_byte;
	assign rx_par_err_o = par_err;
	assign integ_err_o = err_q;
	assign crc_seed_o = seed_q;
	assign crc_type5_o = chk_q[RXG_TYPE5_BIT];
	assign crc_inv_o = chk_q[RXG_INV_BIT];
	assign crc_en_o = chk_q[RXG_CRCEN_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic [19:0] rel_w;
	logic [7:0] pre_w;
	assign rel_w = grd_q[RXG_RELOAD_LSB +: RXG_RELOAD_W];
	assign pre_w = grd_q[RXG_PRESC_LSB +: RXG_PRESC_W];

	chk_guard_off: assert property (guard_trig_i && rel_w == '0 |=> rx_allow_o)
		else $error("zero reload did not disable the guard");
	chk_guard_len: assert property (guard_trig_i && rel_w == 20'h00001 && pre_w == 8'h02
		##1 (!guard_trig_i) [*4] |-> rx_allow_o && !$past(rx_allow_o))
		else $error("guard length not reload times prescaler period");
	chk_start_block: assert property (rx_start_i && !rx_allow_o && !active |=> !active)
		else $error("frame accepted during guard time");
	chk_seed_b: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == RXG_SEL_B
		&& !$past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o == RXG_SEED_B)
		else $error("fixed seed for selector 011b wrong");
	chk_seed_arb: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == RXG_SEL_ARB
		&& !$past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o == $past(chk_q[31:16]))
		else $error("arbitrary seed not used");
	chk_seed_five: assert property ($past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o[15:8] == 8'h00)
		else $error("5-bit crc seed has upper byte");
	chk_par_flag: assert property (rx_par_err_o |=> integ_err_o)
		else $error("parity error did not set integrity flag");
	chk_err_clear: assert property (integ_err_o && acc_start && !par_err && !crc_err_i
		|=> !integ_err_o)
		else $error("integrity flag not cleared at new reception");
	chk_md_a: assert property (md_valid_i && md_proto_i == RXG_PROTO_A
		|=> chk_q[RXG_PAR_EN_BIT] && chk_q[RXG_PAR_ODD_BIT]
		&& chk_q[RXG_SEL_LSB +: 3] == RXG_SEL_A)
		else $error("type A detection did not set parity and seed");
	chk_md_b: assert property (md_valid_i && md_proto_i == RXG_PROTO_B
		|=> chk_q[RXG_SEL_LSB +: 3] == RXG_SEL_B)
		else $error("type B detection did not load seed select");
	chk_md_jis: assert property (md_valid_i && md_proto_i == RXG_PROTO_JIS
		|=> chk_q[RXG_SEL_LSB +: 3] == RXG_SEL_ZERO)
		else $error("JIS detection did not clear seed select");
	chk_seed_a: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == RXG_SEL_A
		&& !$past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o == RXG_SEED_A)
		else $error("fixed seed for selector 001b wrong");
	chk_seed_a671: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == RXG_SEL_A671
		&& !$past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o == RXG_SEED_A671)
		else $error("fixed seed for selector 010b wrong");
	chk_seed_e012: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == RXG_SEL_E012
		&& !$past(chk_q[RXG_TYPE5_BIT]) |-> crc_seed_o == RXG_SEED_E012)
		else $error("fixed seed for selector 101b wrong");
	chk_seed_rsvd: assert property ($past(chk_q[RXG_SEL_LSB +: 3]) == 3'h6
		|-> crc_seed_o == RXG_SEED_ZERO)
		else $error("reserved selector did not give a zero seed");
	chk_guard_on: assert property (guard_trig_i && rel_w != '0 |=> !rx_allow_o)
		else $error("nonzero reload did not start the guard");
	chk_err_hold: assert property (integ_err_o && !acc_start |=> integ_err_o)
		else $error("integrity flag dropped outside a new reception");
	chk_par_pair: assert property (rx_par_err_o |-> rx_byte_valid_o)
		else $error("parity error pulse without its byte");
	chk_check_wr: assert property (wr_en && sel_chk && pstrb_i == 4'hF && !md_valid_i
		|=> chk_q == ($past(pwdata_i) & RXG_CHECK_MASK))
		else $error("check register write not stored");

	cov_guard_end: cover property ($rose(rx_allow_o));
	cov_md_a: cover property (md_valid_i && md_proto_i == RXG_PROTO_A);
	cov_err_frame: cover property (rx_par_err_o ##[1:40] rx_byte_valid_o);
endmodule : rxg_top
`default_nettype wire

/* src/rxg_pkg.sv */
// rxg_pkg: register map, field layout and crc seed table of the receive guard and check block
//
// Behaviour
// - guard timer reloads from a 20-bit field; a reload of zero disables the guard
// - guard timer is driven through a prescaler reloaded from the 8-bit low field
// - a 16-bit programmable crc seed sits in bits 31:16 of the check register
// - parity type bit 0 selects even parity, 1 selects odd parity
// - with parity enabled one parity bit follows each byte, is removed and checked
// - a wrong parity bit sets the integrity error flag; reception carries on
// - mode detector sets parity enable and parity type when type A is recognised
// - bits after a collision are cleared unless the keep bit is set
// - first received bit lands at the aligned bit position, then following positions
// - seed selector picks 0000h, 6363h, A671h, FFFFh, 0012h or E012h; 110b reserved
// - with the 5-bit crc only the low byte of the chosen seed is used
// - mode detector loads seed select 000b for JIS, 001b for type A, 011b for type B
// - seed selector 111b uses the programmed 16-bit arbitrary seed
// - integrity error flag clears by itself at the start of the next reception
package rxg_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] RXG_GUARD_IDX = 6'h11;
	localparam logic [5:0] RXG_CHECK_IDX = 6'h12;
	localparam logic [5:0] RXG_STAT_IDX = 6'h14;
	localparam logic [31:0] RXG_GUARD_RST = 32'h0000_0000;
	localparam logic [31:0] RXG_CHECK_RST = 32'h0000_0000;
	localparam logic [31:0] RXG_GUARD_MASK = 32'h0FFF_FFFF;
	localparam logic [31:0] RXG_CHECK_MASK = 32'hFFFF_0FFF;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RXG_RELOAD_LSB = 8;
	localparam int RXG_RELOAD_W = 20;
	localparam int RXG_PRESC_LSB = 0;
	localparam int RXG_PRESC_W = 8;
	localparam int RXG_PRESET_LSB = 16;
	localparam int RXG_PAR_ODD_BIT = 11;
	localparam int RXG_PAR_EN_BIT = 10;
	localparam int RXG_KEEP_BIT = 9;
	localparam int RXG_ALIGN_LSB = 6;
	localparam int RXG_SEL_LSB = 3;
	localparam int RXG_TYPE5_BIT = 2;
	localparam int RXG_INV_BIT = 1;
	localparam int RXG_CRCEN_BIT = 0;
	localparam int RXG_ST_BUSY_BIT = 0;
	localparam int RXG_ST_ERR_BIT = 1;
	localparam int RXG_ST_ACT_BIT = 2;
	localparam int RXG_ST_BYTE_LSB = 8;

	// ----------------------------------------------------------------
	// crc seed table
	// ----------------------------------------------------------------
	localparam logic [2:0] RXG_SEL_ZERO = 3'h0;
	localparam logic [2:0] RXG_SEL_A = 3'h1;
	localparam logic [2:0] RXG_SEL_A671 = 3'h2;
	localparam logic [2:0] RXG_SEL_B = 3'h3;
	localparam logic [2:0] RXG_SEL_0012 = 3'h4;
	localparam logic [2:0] RXG_SEL_E012 = 3'h5;
	localparam logic [2:0] RXG_SEL_ARB = 3'h7;
	localparam logic [15:0] RXG_SEED_ZERO = 16'h0000;
	localparam logic [15:0] RXG_SEED_A = 16'h6363;
	localparam logic [15:0] RXG_SEED_A671 = 16'hA671;
	localparam logic [15:0] RXG_SEED_B = 16'hFFFF;
	localparam logic [15:0] RXG_SEED_0012 = 16'h0012;
	localparam logic [15:0] RXG_SEED_E012 = 16'hE012;

	typedef enum logic [1:0] {
		RXG_PROTO_JIS = 2'b00,
		RXG_PROTO_A = 2'b01,
		RXG_PROTO_B = 2'b10
	} rxg_proto_t;

	// reserved selector 110b falls back to a zero seed
	function automatic logic [15:0] rxg_seed(input logic [2:0] sel, input logic [15:0] arb,
		input logic five);
		logic [15:0] s;
		s = RXG_SEED_ZERO;
		unique case (sel)
			RXG_SEL_A: s = RXG_SEED_A;
			RXG_SEL_A671: s = RXG_SEED_A671;
			RXG_SEL_B: s = RXG_SEED_B;
			RXG_SEL_0012: s = RXG_SEED_0012;
			RXG_SEL_E012: s = RXG_SEED_E012;
			RXG_SEL_ARB: s = arb;
			default: s = RXG_SEED_ZERO;
		endcase
		if (five) begin
			s = {8'h00, s[7:0]};
		end
		return s;
	endfunction : rxg_seed

	function automatic logic [31:0] rxg_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r & mask;
	endfunction : rxg_merge

endpackage : rxg_pkg

/* src/rxg_guard.sv */
// rxg_guard: prescaled receive guard timer
`timescale 1ns/100ps
`default_nettype none
module rxg_guard
	import rxg_pkg::*;
#(
	parameter int PRESC_W = RXG_PRESC_W,
	parameter int RELOAD_W = RXG_RELOAD_W
) (
	input wire logic clk_i, // clock
	input wire logic rstn_i, // async reset, low
	input wire logic trig_i, // guard start event
	input wire logic [PRESC_W-1:0] presc_i, // prescaler reload
	input wire logic [RELOAD_W-1:0] reload_i, // main count reload
	output logic busy_o // guard time running
);
	logic [PRESC_W-1:0] pcnt_q, pcnt_d;
	logic [RELOAD_W-1:0] main_q, main_d;

	always_comb begin
		pcnt_d = pcnt_q;
		main_d = main_q;
		if (trig_i) begin
			// a zero reload leaves the main count idle, so no guard at all
			main_d = reload_i;
			pcnt_d = presc_i;
		end else if (main_q != '0) begin
			if (pcnt_q == '0) begin
				pcnt_d = presc_i;
				main_d = main_q - 1'b1;
			end else begin
				pcnt_d = pcnt_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pcnt_q <= '0;
			main_q <= '0;
		end else begin
			pcnt_q <= pcnt_d;
			main_q <= main_d;
		end
	end

	assign busy_o = (main_q != '0);

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	chk_guard_step: assert property (main_q != '0 && pcnt_q == '0 && !trig_i
		|=> main_q == $past(main_q) - 1'b1)
		else $error("guard main count did not step on prescaler expiry");
endmodule : rxg_guard
`default_nettype wire

/* src/rxg_pack.sv */
// rxg_pack: receive bit assembly with alignment, collision masking and parity strip
`timescale 1ns/100ps
`default_nettype none
module rxg_pack
	import rxg_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rstn_i, // async reset, low
	input wire logic start_i, // accepted frame start
	input wire logic end_i, // frame end
	input wire logic bit_valid_i, // one received bit
	input wire logic bit_i, // bit value
	input wire logic coll_i, // collision on this bit
	input wire logic par_en_i, // parity bit follows each byte
	input wire logic par_odd_i, // odd parity when high
	input wire logic keep_i, // keep bits after collision
	input wire logic [2:0] align_i, // first bit position
	output logic byte_valid_o, // byte done, one cycle
	output logic [7:0] byte_o, // assembled byte
	output logic par_err_o, // wrong parity, one cycle
	output logic active_o // frame in progress
);
	typedef enum logic [1:0] {
		RXG_IDLE = 2'b00,
		RXG_DATA = 2'b01,
		RXG_PAR = 2'b10
	} rxg_pk_state_t;

	localparam logic [2:0] LAST_POS = 3'h7;

	rxg_pk_state_t st_q, st_d;
	logic [2:0] pos_q, pos_d;
	logic [7:0] buf_q, buf_d, byte_q, byte_d;
	logic coll_q, coll_d, bv_q, bv_d, err_q, err_d;

	always_comb begin
		logic [7:0] nb;
		nb = buf_q;
		st_d = st_q;
		pos_d = pos_q;
		buf_d = buf_q;
		coll_d = coll_q;
		byte_d = byte_q;
		bv_d = 1'b0;
		err_d = 1'b0;
		if (start_i) begin
			st_d = RXG_DATA;
			pos_d = align_i;
			buf_d = '0;
			coll_d = 1'b0;
		end else if (end_i) begin
			// a trailing partial byte is left to the frame logic
			st_d = RXG_IDLE;
		end else if (bit_valid_i) begin
			unique case (st_q)
				RXG_IDLE: begin
					st_d = RXG_IDLE;
				end
				RXG_DATA: begin
					nb[pos_q] = bit_i & (keep_i | ~coll_q);
					coll_d = coll_q | coll_i;
					if (pos_q == LAST_POS) begin
						pos_d = '0;
						if (par_en_i) begin
							buf_d = nb;
							st_d = RXG_PAR;
						end else begin
							byte_d = nb;
							bv_d = 1'b1;
							buf_d = '0;
						end
					end else begin
						buf_d = nb;
						pos_d = pos_q + 3'h1;
					end
				end
				RXG_PAR: begin
					// parity bit is consumed here and never reaches the byte
					byte_d = buf_q;
					bv_d = 1'b1;
					err_d = (bit_i != ((^buf_q) ^ par_odd_i));
					buf_d = '0;
					st_d = RXG_DATA;
				end
				default: begin
					st_d = RXG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= RXG_IDLE;
			pos_q <= '0;
			buf_q <= '0;
			coll_q <= 1'b0;
			byte_q <= '0;
			bv_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pos_q <= pos_d;
			buf_q <= buf_d;
			coll_q <= coll_d;
			byte_q <= byte_d;
			bv_q <= bv_d;
			err_q <= err_d;
		end
	end

	assign byte_valid_o = bv_q;
	assign byte_o = byte_q;
	assign par_err_o = err_q;
	assign active_o = (st_q != RXG_IDLE);

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	logic plain_bit;
	assign plain_bit = bit_valid_i && !start_i && !end_i;

	chk_first_pos: assert property (start_i |=> pos_q == $past(align_i) && buf_q == '0)
		else $error("first bit position not taken from alignment");
	chk_par_slot: assert property (st_q == RXG_DATA && pos_q == LAST_POS && plain_bit && par_en_i
		|=> !byte_valid_o && st_q == RXG_PAR)
		else $error("byte released before its parity bit");
	chk_par_even: assert property (st_q == RXG_PAR && plain_bit && !par_odd_i
		&& (bit_i == ^buf_q) |=> !par_err_o && byte_valid_o)
		else $error("correct even parity flagged");
	chk_coll_clear: assert property (st_q == RXG_DATA && plain_bit && coll_q && !keep_i
		&& pos_q != LAST_POS |=> buf_q[$past(pos_q)] == 1'b0)
		else $error("bit after collision not cleared");
	cov_par_err: cover property (par_err_o);
	cov_byte_aligned: cover property (start_i && align_i != '0 ##[1:40] byte_valid_o);
endmodule : rxg_pack
`default_nettype wire

/* test/rxg_card.sv */
// rxg_card: behavioural far-side card that sends one frame of decoded bits
`timescale 1ns/100ps
`default_nettype none
module rxg_card (
	input wire logic clk_i, // clock
	input wire logic rstn_i, // async reset, low
	input wire logic go_i, // send one frame
	input wire logic [8:0] bits_i, // frame bits, lsb first
	input wire logic [3:0] n_i, // number of bits
	input wire logic [3:0] coll_i, // index of the colliding bit
	output logic start_o, // frame start
	output logic end_o, // frame end
	output logic bv_o, // bit strobe
	output logic bit_o, // bit value
	output logic coll_o, // collision on this bit
	output logic busy_o // frame in flight
);
	logic [3:0] idx_q;

	// idle bit line toggles so a stale value never passes for data
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_o <= 1'h0;
			end_o <= 1'h0;
			bv_o <= 1'h0;
			bit_o <= 1'h0;
			coll_o <= 1'h0;
			busy_o <= 1'h0;
			idx_q <= 4'h0;
		end else begin
			start_o <= go_i;
			end_o <= 1'h0;
			bv_o <= 1'h0;
			coll_o <= 1'h0;
			if (go_i) begin
				busy_o <= 1'h1;
				idx_q <= 4'h0;
			end else if (busy_o && idx_q == n_i) begin
				end_o <= 1'h1;
				busy_o <= 1'h0;
				bit_o <= ~bit_o;
			end else if (busy_o) begin
				bv_o <= 1'h1;
				bit_o <= bits_i[idx_q];
				coll_o <= (idx_q == coll_i);
				idx_q <= idx_q + 4'h1;
			end else begin
				bit_o <= ~bit_o;
			end
		end
	end
endmodule : rxg_card
`default_nettype wire

/* test/tb_rxg_top.sv */
// tb_rxg_top: self-checking bench for the receive guard and check block
`timescale 1ns/100ps
`default_nettype none
module tb_rxg_top;
	import rxg_pkg::*;
	localparam logic [7:0] AG = {RXG_GUARD_IDX, 2'h0};
	localparam logic [7:0] AC = {RXG_CHECK_IDX, 2'h0};
	logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, guard_trig_i, crc_err_i, md_valid_i;
	logic [7:0] paddr_i, rx_byte_o, got_b;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0] pstrb_i, cn, ccoll;
	logic [1:0] md_proto_i;
	logic pready_o, pslverr_o, rx_start_i, rx_end_i, rx_bit_valid_i, rx_bit_i, rx_coll_i;
	logic rx_allow_o, rx_byte_valid_o, rx_par_err_o, integ_err_o, crc_type5_o, crc_inv_o;
	logic crc_en_o, go, cbusy, err;
	logic [15:0] crc_seed_o;
	logic [8:0] cbits;
	int failures = 0;
	int tests_run = 0;
	int nbytes = 0;
	int nperr = 0;

	rxg_top dut (.clk_i, .rstn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
		.pstrb_i, .prdata_o, .pready_o, .pslverr_o, .guard_trig_i, .rx_start_i, .rx_end_i,
		.rx_bit_valid_i, .rx_bit_i, .rx_coll_i, .crc_err_i, .md_valid_i, .md_proto_i,
		.rx_allow_o, .rx_byte_valid_o, .rx_byte_o, .rx_par_err_o, .integ_err_o, .crc_seed_o,
		.crc_type5_o, .crc_inv_o, .crc_en_o);
	rxg_card card (.clk_i, .rstn_i, .go_i(go), .bits_i(cbits), .n_i(cn), .coll_i(ccoll),
		.start_o(rx_start_i), .end_o(rx_end_i), .bv_o(rx_bit_valid_i), .bit_o(rx_bit_i),
		.coll_o(rx_coll_i), .busy_o(cbusy));

	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (rx_byte_valid_o === 1'h1) begin
			got_b = rx_byte_o;
			nbytes++;
			if (rx_par_err_o === 1'h1) nperr++;
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task give_verdict;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task hang;
		failures++;
		give_verdict();
	endtask : hang

	// wait states are tolerated: the access phase lasts until pready is seen, up to 20 cycles
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (pready_o === 1'h1) break;
		end
		if (i == 20) hang();
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask : apb

	task send(input logic [8:0] b, input logic [3:0] n, input logic [3:0] c);
		int i;
		@(posedge clk_i);
		go <= 1'h1;
		cbits <= b;
		cn <= n;
		ccoll <= c;
		@(posedge clk_i);
		go <= 1'h0;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_i);
			if (cbusy === 1'h0) break;
		end
		if (i == 40) hang();
		repeat (2) @(posedge clk_i);
	endtask : send

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		apb(1'h0, AG, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'h0, AC, 32'h0);
		chk(rd, 32'h0000_0000);
		apb(1'h1, AG, 32'hFFFF_FFFF);
		apb(1'h0, AG, 32'h0);
		chk(rd, 32'h0FFF_FFFF);
		apb(1'h1, AC, 32'hFFFF_FFFF);
		apb(1'h0, AC, 32'h0);
		chk(rd, 32'hFFFF_0FFF);
		apb(1'h0, 8'h4C, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'h1);
	endtask : t_regs

	task t_seed;
		logic [15:0] tbl [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF, 16'h0012, 16'hE012,
			16'h0000, 16'hBEEF};
		for (int s = 0; s < 8; s++) begin
			apb(1'h1, AC, {16'hBEEF, 10'h0, s[2:0], 3'h1});
			repeat (2) @(posedge clk_i);
			chk(crc_seed_o, tbl[s]);
		end
		apb(1'h1, AC, {16'hBEEF, 10'h0, 3'h1, 3'h4});
		repeat (2) @(posedge clk_i);
		chk(crc_seed_o, 16'h0063);
		chk(crc_type5_o, 1'h1);
		apb(1'h1, AC, 32'h0);
	endtask : t_seed

	// a frame is offered while the guard runs and must be ignored
	task t_guard(input logic [19:0] rl, input logic [7:0] pr);
		int n;
		int nb;
		nb = nbytes;
		apb(1'h1, AG, {4'h0, rl, pr});
		@(posedge clk_i);
		guard_trig_i <= 1'h1;
		go <= (rl != 20'h0);
		cbits <= 9'h0FF;
		cn <= 4'h8;
		ccoll <= 4'hF;
		@(posedge clk_i);
		guard_trig_i <= 1'h0;
		go <= 1'h0;
		for (n = 0; n < 2000; n++) begin
			@(posedge clk_i);
			if (rx_allow_o === 1'h1) break;
		end
		if (n == 2000) hang();
		chk(n, int'(rl) * (int'(pr) + 1));
		chk(nbytes, nb);
	endtask : t_guard

	task t_stream;
		int nb;
		int ne;
		nb = nbytes;
		ne = nperr;
		apb(1'h1, AC, 32'h0000_0C00);
		send(9'h1A5, 4'h9, 4'hF);
		chk(got_b, 8'hA5);
		chk(nperr, ne);
		send(9'h0A5, 4'h9, 4'hF);
		chk(nperr, ne + 1);
		chk(integ_err_o, 1'h1);
		chk(nbytes, nb + 2);
		apb(1'h1, AC, 32'h0000_0400);
		send(9'h0A5, 4'h9, 4'hF);
		chk(nperr, ne + 1);
		chk(integ_err_o, 1'h0);
		@(posedge clk_i);
		crc_err_i <= 1'h1;
		@(posedge clk_i);
		crc_err_i <= 1'h0;
		@(posedge clk_i);
		chk(integ_err_o, 1'h1);
		apb(1'h1, AC, 32'h0000_00C0);
		send(9'h016, 4'h5, 4'hF);
		chk(got_b, 8'hB0);
		chk(integ_err_o, 1'h0);
		apb(1'h1, AC, 32'h0);
		send(9'h0FF, 4'h8, 4'h2);
		chk(got_b, 8'h07);
		apb(1'h1, AC, 32'h0000_0200);
		send(9'h0FF, 4'h8, 4'h2);
		chk(got_b, 8'hFF);
		apb(1'h0, {RXG_STAT_IDX, 2'h0}, 32'h0);
		chk(rd, 32'h0000_FF00);
	endtask : t_stream

	task t_md;
		logic [1:0] pt [3] = '{RXG_PROTO_A, RXG_PROTO_B, RXG_PROTO_JIS};
		logic [31:0] ex [3] = '{32'h0000_0C08, 32'h0000_0C1B, 32'h0000_0C01};
		apb(1'h1, AC, 32'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			md_valid_i <= 1'h1;
			md_proto_i <= pt[i];
			@(posedge clk_i);
			md_valid_i <= 1'h0;
			apb(1'h0, AC, 32'h0);
			chk(rd, ex[i]);
			chk(crc_inv_o, ex[i][1]);
			chk(crc_en_o, ex[i][0]);
		end
	endtask : t_md

	initial begin
		rstn_i = 1'h0;
		{psel_i, penable_i, pwrite_i, guard_trig_i, crc_err_i, md_valid_i, go} = 7'h0;
		paddr_i = 8'h0;
		pwdata_i = 32'h0;
		pstrb_i = 4'hF;
		md_proto_i = 2'h0;
		cbits = 9'h0;
		cn = 4'h0;
		ccoll = 4'hF;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'h1;
		t_regs();
		t_seed();
		t_guard(20'h000A0, 8'h00);
		t_guard(20'h00003, 8'h7F);
		t_guard(20'h00001, 8'h02);
		t_guard(20'h00000, 8'h7F);
		t_stream();
		t_md();
		give_verdict();
	end
endmodule : tb_rxg_top
`default_nettype wire
